// File: logic/gtfs_pkg.sv
// Package for the pin edge and temperature fault status bank.
// Assumes a 32-bit APB slave; each register is one aligned word.
package gtfs_pkg;
	// ----------------------------------------
	// Register map
	// ----------------------------------------
	// Printed offsets are not all multiples of four: they are word indices
	localparam logic [7:0] GTFS_IDX_GPIO_STS = 8'h1f;
	localparam logic [7:0] GTFS_IDX_TEMP_FLT = 8'h20;
	localparam int GTFS_ADDR_W = 12;
	localparam logic [GTFS_ADDR_W-1:0] GTFS_ADDR_GPIO_STS = {2'h0, GTFS_IDX_GPIO_STS, 2'h0};
	localparam logic [GTFS_ADDR_W-1:0] GTFS_ADDR_TEMP_FLT = {2'h0, GTFS_IDX_TEMP_FLT, 2'h0};
	// ----------------------------------------
	// Field layout
	// ----------------------------------------
	localparam int GTFS_NCH = 7;
	localparam int GTFS_LO_LSB = 0;
	localparam int GTFS_HI_LSB = 8;
	localparam logic [15:0] GTFS_RESET_VAL = 16'h0000;
	// ----------------------------------------
	// Carrier types
	// ----------------------------------------
	typedef struct packed {
		logic [GTFS_NCH-1:0] over;
		logic [GTFS_NCH-1:0] under;
	} gtfs_temp_t;
	typedef struct packed {
		logic [GTFS_NCH-1:0] rise_flag;
		logic [GTFS_NCH-1:0] level_prev;
		gtfs_temp_t temp;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} gtfs_state_t;
	typedef enum logic [1:0] {
		GTFS_IDLE = 2'b01,
		GTFS_DONE = 2'b10
	} gtfs_phase_t;
endpackage : gtfs_pkg

// File: logic/gtfs_status_bank.sv
// Pin rise latch and temperature fault status registers behind APB.
// Assumes pin levels and fault detect strobes are synchronous to pclk.
//
// Overview of operation
// R01: Latch sticky rise flag per pin
// R02: Flag reads 0 until high seen
// R03: Write 0 clears flag, 1 keeps
// R04: Reset clears all sticky flags
// R05: Set under-temp flag on detected fault
// R06: Later conversion sets flag again if persisting
// R07: Low bits give live pin level
`timescale 1ns/1ps
module gtfs_status_bank
	import gtfs_pkg::*;
#(
	parameter int NCH = GTFS_NCH
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [GTFS_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [GTFS_NCH-1:0] pin_live_level,
	input wire logic [GTFS_NCH-1:0] under_temp_detect,
	input wire logic [GTFS_NCH-1:0] over_temp_detect
);
	gtfs_state_t st;
	gtfs_state_t next_st;
	gtfs_phase_t phase;
	logic [GTFS_NCH-1:0] rise;
	logic setup;
	logic access;
	logic hit_gpio;
	logic hit_temp;
	logic rd_gpio;
	logic rd_temp;
	logic wr_gpio;
	logic wr_temp;

	// ----------------------------------------
	// Elaboration checks
	// ----------------------------------------
	if (NCH != GTFS_NCH) begin : g_bad_nch
		$error("channel count must match the register layout");
	end
	if (GTFS_LO_LSB + NCH > GTFS_HI_LSB) begin : g_overlap
		$error("low and high fields overlap");
	end

	// ----------------------------------------
	// Decode helpers
	// ----------------------------------------
	// Full address match, unused low bits included
	function automatic logic addr_hit(input logic [GTFS_ADDR_W-1:0] addr,
		input logic [GTFS_ADDR_W-1:0] target);
		return addr == target;
	endfunction : addr_hit

	// ----------------------------------------
	// Transfer phase
	// ----------------------------------------
	// Access phase coincides with the registered ready pulse
	assign phase = st.pready ? GTFS_DONE : GTFS_IDLE;

	always_comb begin
		access = 1'b0;
		case (phase)
			GTFS_IDLE: begin
				access = 1'b0;
			end
			GTFS_DONE: begin
				access = psel && penable;
			end
			default: begin
				access = 1'b0;
			end
		endcase
	end

	function automatic logic [GTFS_NCH-1:0] zero_write_clear(input logic [GTFS_NCH-1:0] flag,
		input logic [GTFS_NCH-1:0] set, input logic [GTFS_NCH-1:0] wdata, input logic wr);
		logic [GTFS_NCH-1:0] kept;
		kept = wr ? (flag & wdata) : flag;
		return kept | set;
	endfunction : zero_write_clear

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		next_st = st;
		setup = psel && !penable;
		rise = pin_live_level & ~st.level_prev;
		hit_gpio = addr_hit(paddr, GTFS_ADDR_GPIO_STS);
		hit_temp = addr_hit(paddr, GTFS_ADDR_TEMP_FLT);
		rd_gpio = setup && !pwrite && hit_gpio;
		rd_temp = setup && !pwrite && hit_temp;
		// Writes land at the edge that ends the access phase
		wr_gpio = access && pwrite && hit_gpio;
		wr_temp = access && pwrite && hit_temp;
		next_st.level_prev = pin_live_level;
		// Set wins over a simultaneous clear
		next_st.rise_flag = zero_write_clear(st.rise_flag, rise,
			pwdata[GTFS_HI_LSB +: GTFS_NCH], wr_gpio); // R01 R02 R03
		next_st.temp.under = zero_write_clear(st.temp.under, under_temp_detect,
			pwdata[GTFS_LO_LSB +: GTFS_NCH], wr_temp); // R05 R06 R03
		next_st.temp.over = zero_write_clear(st.temp.over, over_temp_detect,
			pwdata[GTFS_HI_LSB +: GTFS_NCH], wr_temp);
		next_st.pready = setup;
		next_st.pslverr = 1'b0;
		next_st.prdata = '0;
		if (rd_gpio) begin
			next_st.prdata[GTFS_HI_LSB +: GTFS_NCH] = st.rise_flag;
			next_st.prdata[GTFS_LO_LSB +: GTFS_NCH] = pin_live_level; // R07
		end else if (rd_temp) begin
			next_st.prdata[GTFS_HI_LSB +: GTFS_NCH] = st.temp.over;
			next_st.prdata[GTFS_LO_LSB +: GTFS_NCH] = st.temp.under;
		end else if (setup && !hit_gpio && !hit_temp) begin
			// Unmapped: read as zero, write dropped
			next_st.pslverr = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0; // R04
		end else begin
			st <= next_st;
		end
	end

	assign prdata = st.prdata;
	assign pready = st.pready;
	assign pslverr = st.pslverr;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	rise_sets_flag_a: assert property (@(posedge pclk) disable iff (!presetn) // R01
		(pin_live_level[0] && !st.level_prev[0]) |=> st.rise_flag[0])
		else $error("rise not latched");
	flag_needs_high_a: assert property (@(posedge pclk) disable iff (!presetn) // R02
		$rose(st.rise_flag[0]) |-> $past(pin_live_level[0]))
		else $error("flag set without high");
	zero_clears_a: assert property (@(posedge pclk) disable iff (!presetn) // R03
		(wr_gpio && !pwdata[GTFS_HI_LSB] && !rise[0]) |=> !st.rise_flag[0])
		else $error("clear failed");
	one_keeps_a: assert property (@(posedge pclk) disable iff (!presetn) // R03
		(wr_temp && pwdata[GTFS_LO_LSB] && st.temp.under[0]) |=> st.temp.under[0])
		else $error("flag lost");
	reset_clears_a: assert property (@(posedge pclk) // R04
		!presetn |-> (st.rise_flag == '0) && ({1'b0, st.temp.over, 1'b0, st.temp.under} == GTFS_RESET_VAL))
		else $error("reset value wrong");
	under_sets_a: assert property (@(posedge pclk) disable iff (!presetn) // R05
		under_temp_detect[0] |=> st.temp.under[0])
		else $error("under temp not set");
	reset_again_a: assert property (@(posedge pclk) disable iff (!presetn) // R06
		(wr_temp && under_temp_detect[1]) |=> st.temp.under[1])
		else $error("persist lost");
	live_level_a: assert property (@(posedge pclk) disable iff (!presetn) // R07
		(setup && !pwrite && hit_gpio) |=> pready
		&& (prdata[GTFS_LO_LSB +: GTFS_NCH] == $past(pin_live_level)))
		else $error("level wrong");

	// ----------------------------------------
	// Register bus checks
	// ----------------------------------------
	ready_once_a: assert property (@(posedge pclk) disable iff (!presetn)
		pready |=> !pready)
		else $error("ready held too long");
	ready_follows_a: assert property (@(posedge pclk) disable iff (!presetn)
		setup |=> pready)
		else $error("setup not answered");
	idle_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
		!pready |-> (prdata == '0) && !pslverr)
		else $error("bus outputs not idle");
	error_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
		pslverr |-> pready && (prdata == '0))
		else $error("error reply with data");
	write_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
		(setup && pwrite) |=> (prdata == '0))
		else $error("write returned data");
	addr_err_a: assert property (@(posedge pclk) disable iff (!presetn)
		(setup && !hit_gpio && !hit_temp) |=> pslverr)
		else $error("unmapped address accepted");
	addr_good_a: assert property (@(posedge pclk) disable iff (!presetn)
		(setup && (hit_gpio || hit_temp)) |=> !pslverr)
		else $error("mapped address refused");

	// ----------------------------------------
	// Per channel checks
	// ----------------------------------------
	for (genvar ch = 0; ch < GTFS_NCH; ch++) begin : g_chan_chk
		// Pin edge flags
		chan_rise_a: assert property (@(posedge pclk) disable iff (!presetn) // R01
			(pin_live_level[ch] && !st.level_prev[ch]) |=> st.rise_flag[ch])
			else $error("pin rise not latched");
		chan_no_rise_a: assert property (@(posedge pclk) disable iff (!presetn) // R02
			(!st.rise_flag[ch] && !rise[ch]) |=> !st.rise_flag[ch])
			else $error("flag set without rise");
		chan_gpio_clear_a: assert property (@(posedge pclk) disable iff (!presetn) // R03
			(wr_gpio && !pwdata[GTFS_HI_LSB + ch] && !rise[ch]) |=> !st.rise_flag[ch])
			else $error("pin flag not cleared");
		chan_gpio_keep_a: assert property (@(posedge pclk) disable iff (!presetn) // R03
			(wr_gpio && pwdata[GTFS_HI_LSB + ch] && st.rise_flag[ch]) |=> st.rise_flag[ch])
			else $error("pin flag lost on write one");
		chan_set_wins_a: assert property (@(posedge pclk) disable iff (!presetn) // R01
			(wr_gpio && rise[ch]) |=> st.rise_flag[ch])
			else $error("clear beat a rise");
		chan_rise_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // R01
			(st.rise_flag[ch] && !wr_gpio) |=> st.rise_flag[ch])
			else $error("pin flag not sticky");
		chan_gpio_other_a: assert property (@(posedge pclk) disable iff (!presetn) // R03
			(wr_temp && st.rise_flag[ch]) |=> st.rise_flag[ch])
			else $error("pin flag hit by other write");
		chan_prev_track_a: assert property (@(posedge pclk) disable iff (!presetn) // R01
			pin_live_level[ch] |=> st.level_prev[ch])
			else $error("previous level not kept");
		chan_prev_low_a: assert property (@(posedge pclk) disable iff (!presetn) // R01
			!pin_live_level[ch] |=> !st.level_prev[ch])
			else $error("previous level stuck high");
		// Temperature flags
		chan_under_set_a: assert property (@(posedge pclk) disable iff (!presetn) // R05
			under_temp_detect[ch] |=> st.temp.under[ch])
			else $error("under temp not set");
		chan_over_set_a: assert property (@(posedge pclk) disable iff (!presetn) // R05
			over_temp_detect[ch] |=> st.temp.over[ch])
			else $error("over temp not set");
		chan_under_clear_a: assert property (@(posedge pclk) disable iff (!presetn) // R03
			(wr_temp && !pwdata[GTFS_LO_LSB + ch] && !under_temp_detect[ch]) |=> !st.temp.under[ch])
			else $error("under flag not cleared");
		chan_over_clear_a: assert property (@(posedge pclk) disable iff (!presetn) // R03
			(wr_temp && !pwdata[GTFS_HI_LSB + ch] && !over_temp_detect[ch]) |=> !st.temp.over[ch])
			else $error("over flag not cleared");
		chan_under_keep_a: assert property (@(posedge pclk) disable iff (!presetn) // R03
			(st.temp.under[ch] && !(wr_temp && !pwdata[GTFS_LO_LSB + ch])) |=> st.temp.under[ch])
			else $error("under flag not sticky");
		chan_over_keep_a: assert property (@(posedge pclk) disable iff (!presetn) // R03
			(st.temp.over[ch] && !(wr_temp && !pwdata[GTFS_HI_LSB + ch])) |=> st.temp.over[ch])
			else $error("over flag not sticky");
		chan_under_other_a: assert property (@(posedge pclk) disable iff (!presetn) // R03
			(wr_gpio && st.temp.under[ch]) |=> st.temp.under[ch])
			else $error("under flag hit by other write");
		chan_over_other_a: assert property (@(posedge pclk) disable iff (!presetn) // R03
			(wr_gpio && st.temp.over[ch]) |=> st.temp.over[ch])
			else $error("over flag hit by other write");
		chan_under_persist_a: assert property (@(posedge pclk) disable iff (!presetn) // R06
			(wr_temp && under_temp_detect[ch]) |=> st.temp.under[ch])
			else $error("under fault not set again");
		chan_over_persist_a: assert property (@(posedge pclk) disable iff (!presetn) // R06
			(wr_temp && over_temp_detect[ch]) |=> st.temp.over[ch])
			else $error("over fault not set again");
		chan_under_only_a: assert property (@(posedge pclk) disable iff (!presetn) // R05
			$rose(st.temp.under[ch]) |-> $past(under_temp_detect[ch]))
			else $error("under flag set without fault");
		chan_over_only_a: assert property (@(posedge pclk) disable iff (!presetn) // R05
			$rose(st.temp.over[ch]) |-> $past(over_temp_detect[ch]))
			else $error("over flag set without fault");
		// Read data
		chan_level_read_a: assert property (@(posedge pclk) disable iff (!presetn) // R07
			rd_gpio |=> (prdata[GTFS_LO_LSB + ch] == $past(pin_live_level[ch])))
			else $error("live level read wrong");
		chan_flag_read_a: assert property (@(posedge pclk) disable iff (!presetn) // R02
			rd_gpio |=> (prdata[GTFS_HI_LSB + ch] == $past(st.rise_flag[ch])))
			else $error("pin flag read wrong");
		chan_under_read_a: assert property (@(posedge pclk) disable iff (!presetn) // R05
			rd_temp |=> (prdata[GTFS_LO_LSB + ch] == $past(st.temp.under[ch])))
			else $error("under flag read wrong");
		chan_over_read_a: assert property (@(posedge pclk) disable iff (!presetn) // R05
			rd_temp |=> (prdata[GTFS_HI_LSB + ch] == $past(st.temp.over[ch])))
			else $error("over flag read wrong");
		chan_reset_a: assert property (@(posedge pclk) // R04
			!presetn |-> !st.rise_flag[ch] && !st.temp.under[ch] && !st.temp.over[ch])
			else $error("channel not reset");
	end

	// ----------------------------------------
	// Coverage
	// ----------------------------------------
	read_gpio_c: cover property (@(posedge pclk) disable iff (!presetn)
		pready && st.prdata[GTFS_HI_LSB] );
	clear_temp_c: cover property (@(posedge pclk) disable iff (!presetn) wr_temp && st.temp.under != '0);
	bad_addr_c: cover property (@(posedge pclk) disable iff (!presetn) pslverr);
	rise_latch_c: cover property (@(posedge pclk) disable iff (!presetn) $rose(st.rise_flag[0]));
	persist_set_c: cover property (@(posedge pclk) disable iff (!presetn)
		wr_temp && (under_temp_detect != '0));
endmodule : gtfs_status_bank

// File: testbench/test_gpio_and_temp_fault_status.sv
// Bench for the pin edge and temperature fault status bank.
// Assumes one APB answer per setup and a single 20 MHz clock.
`timescale 1ns/1ps
module test_gpio_and_temp_fault_status;
	import gtfs_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [GTFS_ADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [GTFS_NCH-1:0] lvl, ut, ot, p, m;
	logic [32:0] q[$];
	int mismatches, checked;
	localparam logic [GTFS_ADDR_W-1:0] A1 = GTFS_ADDR_GPIO_STS;
	localparam logic [GTFS_ADDR_W-1:0] A2 = GTFS_ADDR_TEMP_FLT;
	gtfs_status_bank i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pin_live_level(lvl), .under_temp_detect(ut), .over_temp_detect(ot));
	// ----------------
	// Helpers
	// ----------------
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr
	task automatic compare(input logic [32:0] seen, input logic [32:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value response expected %h seen %h", exp, seen);
		end
	endtask : compare
	task automatic apb(input logic w, input logic [GTFS_ADDR_W-1:0] a, input logic [31:0] d, input logic [32:0] e);
		q.push_back(e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rd(input logic [GTFS_ADDR_W-1:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0, {1'b0, e});
	endtask : rd
	task automatic wr(input logic [GTFS_ADDR_W-1:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 33'h0);
	endtask : wr
	task automatic print_verdict();
		$display("mismatches %0d checked %0d", mismatches, checked);
		if (mismatches == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : print_verdict
	always @(negedge pclk) if (pready === 1'b1 && q.size() != 0) compare({pslverr, prdata}, q.pop_front());
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	initial begin
		#200000;
		mismatches++;
		print_verdict();
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, lvl, ut, ot} = '0;
		r = 32'hc396;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		rd(A1, 32'h0);
		rd(A2, 32'h0);
		repeat (3) begin
			r = lfsr(r);
			p = r[6:0];
			m = r[14:8];
			wr(A1, 32'h0);
			wr(A2, 32'h0);
			lvl <= p;
			rd(A1, {16'h0, 1'b0, p, 1'b0, p});
			lvl <= '0;
			rd(A1, {17'h0, p, 8'h0});
			wr(A1, {17'h0, ~m, 8'hff});
			rd(A1, {17'h0, p & ~m, 8'h0});
			ot <= p;
			ut <= m;
			@(posedge pclk);
			ot <= '0;
			ut <= '0;
			rd(A2, {17'h0, p, 1'b0, m});
			ut <= m;
			wr(A2, 32'h0);
			rd(A2, {25'h0, m});
			ut <= '0;
			wr(A2, 32'h0);
			rd(A2, 32'h0);
		end
		apb(1'b0, 12'h084, 32'h0, {1'b1, 32'h0});
		apb(1'b1, 12'h084, 32'h0, {1'b1, 32'h0});
		ut <= 7'h7f;
		lvl <= 7'h7f;
		@(posedge pclk);
		ut <= '0;
		lvl <= '0;
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd(A1, 32'h0);
		rd(A2, 32'h0);
		repeat (2) @(posedge pclk);
		print_verdict();
	end
endmodule : test_gpio_and_temp_fault_status
